// ===== inc/rpt_pkg.sv
// rms and phase trim datapath: shared constants and register map
// assumes a 100 MHz master clock and AXI4-Lite register access
package rpt_pkg;
    // datapath widths
    localparam int SMP_W    = 16;
    localparam int MS_W     = 32;
    localparam int RT_W     = 16;
    localparam int RES_W    = 24;
    localparam int OFS_W    = 12;
    // phase trim
    localparam int TRIM_W      = 6;
    localparam int PH_STEP_LOG = 3;
    localparam int PH_STEP     = 2 ** PH_STEP_LOG;
    localparam logic [TRIM_W-1:0] PH_CENTER = 6'h0D;
    // current trim scale, 32768
    localparam int IOFS_SHIFT = 15;
    // smoothing filter
    localparam int LPF_SHIFT_DEF = 8;
    // bus
    localparam int AXI_AW = 8;
    localparam int AXI_DW = 32;
    localparam logic [AXI_AW-1:0] A_PHASE_TRIM = 8'h00;
    localparam logic [AXI_AW-1:0] A_VOLTAGE_RMS_RESULT_TRIM  = 8'h04;
    localparam logic [AXI_AW-1:0] A_CURRENT_RMS_RESULT_TRIM  = 8'h08;
    localparam logic [AXI_AW-1:0] A_VOLTAGE_RMS_RESULT_RES   = 8'h0C;
    localparam logic [AXI_AW-1:0] A_CURRENT_RMS_RESULT_RES   = 8'h10;
    localparam logic [AXI_AW-1:0] A_STATUS     = 8'h14;
    localparam logic [AXI_AW-1:0] A_MASK       = 8'h18;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // status and mask bits
    localparam int ST_W    = 3;
    localparam int ST_ZX   = 0;
    localparam int ST_VRDY = 1;
    localparam int ST_IRDY = 2;
endpackage : rpt_pkg

// ===== hdl/rpt_isqrt.sv
// iterative integer square root, one result bit per clock
// assumes start_in is raised only while busy_out is low
`timescale 1ns/1ns
module rpt_isqrt (
    // clock and reset
    input  wire logic                     ref_clk_in,
    input  wire logic                     reset_in,
    // request
    input  wire logic                     start_in,
    input  wire logic [rpt_pkg::MS_W-1:0] radicand_in,
    // answer
    output logic                          busy_out,
    output logic                          done_out,
    output logic [rpt_pkg::RT_W-1:0]      root_out
);
    localparam int MW = rpt_pkg::MS_W;

    if (MW != 2 * rpt_pkg::RT_W || MW % 2 != 0) begin : g_bad_width
        $error("root width must be half the radicand width");
    end

    typedef struct packed {
        logic          busy;
        logic          done;
        logic [MW-1:0] op;
        logic [MW-1:0] res;
        logic [MW-1:0] one;
    } rpt_sqrt_type;

    rpt_sqrt_type  state_ff;
    rpt_sqrt_type  nxt_state;
    logic [MW-1:0] trial;

    always_comb begin
        nxt_state = state_ff;
        nxt_state.done = 1'b0;
        trial = state_ff.res + state_ff.one;
        if (start_in && !state_ff.busy) begin
            nxt_state.busy = 1'b1;
            nxt_state.op = radicand_in;
            nxt_state.res = '0;
            nxt_state.one = MW'(1) << (MW - 2);
        end else if (state_ff.busy) begin
            if (state_ff.op >= trial) begin
                nxt_state.op = state_ff.op - trial;
                nxt_state.res = (state_ff.res >> 1) + state_ff.one;
            end else begin
                nxt_state.res = state_ff.res >> 1;
            end
            nxt_state.one = state_ff.one >> 2;
            if (state_ff.one == MW'(1)) begin
                nxt_state.busy = 1'b0;
                nxt_state.done = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign busy_out = state_ff.busy;
    assign done_out = state_ff.done;
    assign root_out = state_ff.res[rpt_pkg::RT_W-1:0];
endmodule : rpt_isqrt

// ===== hdl/rpt_datapath.sv
// rms and phase trim datapath: trimmed voltage delay, squaring,
// smoothing, shared square root, rms offsets, zero crossing irq
// assumes one sample pair per ref_clk_in cycle from same-clock logic
//
// Operation
// - voltage delay is (trim - 0x0D) * 8 clocks
// - positive difference delays, negative difference advances
// - phase trim is signed two's complement
// - only the voltage channel moves in time
// - correction acts opposite to the phase error
// - each sample squared in a multiplier
// - low-pass mean square, then square root
// - voltage trim added after filter and root
// - voltage trim is 12-bit signed
// - current trim times 32768 added before root
// - interrupt can flag each voltage zero crossing
`timescale 1ns/1ns
module rpt_datapath #(
    parameter int LPF_SHIFT = rpt_pkg::LPF_SHIFT_DEF
) (
    // clock and reset
    input  wire logic                       ref_clk_in,
    input  wire logic                       reset_in,
    // sample streams
    input  wire logic [rpt_pkg::SMP_W-1:0]  voltage_sample_in,
    input  wire logic [rpt_pkg::SMP_W-1:0]  current_sample_in,
    // axi4-lite write
    input  wire logic [rpt_pkg::AXI_AW-1:0] axi_awaddr_in,
    input  wire logic                       axi_awvalid_in,
    output logic                            axi_awready_out,
    input  wire logic [rpt_pkg::AXI_DW-1:0] axi_wdata_in,
    input  wire logic [3:0]                 axi_wstrb_in,
    input  wire logic                       axi_wvalid_in,
    output logic                            axi_wready_out,
    output logic [1:0]                      axi_bresp_out,
    output logic                            axi_bvalid_out,
    input  wire logic                       axi_bready_in,
    // axi4-lite read
    input  wire logic [rpt_pkg::AXI_AW-1:0] axi_araddr_in,
    input  wire logic                       axi_arvalid_in,
    output logic                            axi_arready_out,
    output logic [rpt_pkg::AXI_DW-1:0]      axi_rdata_out,
    output logic [1:0]                      axi_rresp_out,
    output logic                            axi_rvalid_out,
    input  wire logic                       axi_rready_in,
    // interrupt
    output logic                            irq_out
);
    localparam int SW = rpt_pkg::SMP_W;
    localparam int MW = rpt_pkg::MS_W;
    localparam int RW = rpt_pkg::RT_W;
    localparam int TW = rpt_pkg::TRIM_W;
    localparam int OW = rpt_pkg::OFS_W;
    localparam int RSW = rpt_pkg::RES_W;
    localparam int DW = rpt_pkg::AXI_DW;
    localparam int BW = rpt_pkg::AXI_AW;
    localparam int STW = rpt_pkg::ST_W;
    localparam int XW = MW + 2;
    localparam int VW = RW + 2;
    localparam int AW = TW + rpt_pkg::PH_STEP_LOG;
    localparam int DEPTH = 2 ** AW;
    // current path sits at the delay of the centre code, so the
    // voltage path can run ahead of it as well as behind
    localparam logic [AW-1:0] IOFF =
        AW'((int'(rpt_pkg::PH_CENTER) + 2 ** (TW - 1)) * rpt_pkg::PH_STEP);
    localparam logic signed [XW-1:0] ISCALE =
        XW'(2 ** rpt_pkg::IOFS_SHIFT);

    if (LPF_SHIFT < 1 || LPF_SHIFT >= MW) begin : g_bad_shift
        $error("LPF_SHIFT out of range");
    end

    typedef struct packed {
        logic [DEPTH-1:0][2*SW-1:0] mem;
        logic [AW-1:0]              wp;
        logic [SW-1:0]              vdel;
        logic [SW-1:0]              idel;
        logic                       vpos;
        logic [MW-1:0]              vsq;
        logic [MW-1:0]              isq;
        logic [MW-1:0]              vms;
        logic [MW-1:0]              ims;
        logic                       sel;
        logic                       go;
        logic [MW-1:0]              rad;
        logic [TW-1:0]              phase_trim_value;
        logic [OW-1:0]              voltage_rms_trim;
        logic [OW-1:0]              current_rms_trim;
        logic [RSW-1:0]             voltage_rms_result;
        logic [RSW-1:0]             current_rms_result;
        logic [STW-1:0]             stat;
        logic [STW-1:0]             mask;
        logic                       irq;
        logic                       awrdy;
        logic                       wrdy;
        logic                       haw;
        logic                       hw;
        logic [BW-1:0]              awa;
        logic [DW-1:0]              wd;
        logic [3:0]                 ws;
        logic                       bvalid;
        logic [1:0]                 bresp;
        logic                       arrdy;
        logic                       rvalid;
        logic [DW-1:0]              rdata;
        logic [1:0]                 rresp;
    } rpt_state_type;

    rpt_state_type          state_ff;
    rpt_state_type          nxt_state;
    logic [AW-1:0]          voff;
    logic                   sq_busy;
    logic                   sq_done;
    logic [RW-1:0]          sq_root;
    logic signed [VW-1:0]   vsum;
    logic [RW:0]            vclamp;
    logic signed [XW-1:0]   ichk;
    logic [MW-1:0]          icorr;
    logic                   zx;
    logic                   aw_hs;
    logic                   w_hs;
    logic                   ar_hs;
    logic                   do_wr;
    logic [DW-1:0]          mrg;
    logic [DW-1:0]          clr;
    logic [STW-1:0]         ev;

    function automatic logic [MW-1:0] square(input logic [SW-1:0] x);
        logic signed [MW-1:0] e;
        e = MW'($signed(x));
        return MW'(e * e);
    endfunction : square

    function automatic logic [MW-1:0] lpf_step(input logic [MW-1:0] ms,
                                               input logic [MW-1:0] sq);
        logic signed [MW:0] diff;
        diff = $signed({1'b0, sq}) - $signed({1'b0, ms});
        return MW'($signed({1'b0, ms}) + (diff >>> LPF_SHIFT));
    endfunction : lpf_step

    function automatic logic [DW-1:0] strb_merge(input logic [DW-1:0] old,
                                                 input logic [DW-1:0] nw,
                                                 input logic [3:0]    strb);
        logic [DW-1:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction : strb_merge

    function automatic logic addr_hit(input logic [BW-1:0] a);
        logic [BW-1:0] w;
        w = {a[BW-1:2], 2'b00};
        return w == rpt_pkg::A_PHASE_TRIM || w == rpt_pkg::A_VOLTAGE_RMS_RESULT_TRIM ||
               w == rpt_pkg::A_CURRENT_RMS_RESULT_TRIM || w == rpt_pkg::A_VOLTAGE_RMS_RESULT_RES ||
               w == rpt_pkg::A_CURRENT_RMS_RESULT_RES || w == rpt_pkg::A_STATUS ||
               w == rpt_pkg::A_MASK;
    endfunction : addr_hit

    function automatic logic [DW-1:0] reg_read(input logic [BW-1:0] a);
        logic [DW-1:0] r;
        r = '0;
        case ({a[BW-1:2], 2'b00})
            rpt_pkg::A_PHASE_TRIM: r = DW'(state_ff.phase_trim_value);
            rpt_pkg::A_VOLTAGE_RMS_RESULT_TRIM:  r = DW'(state_ff.voltage_rms_trim);
            rpt_pkg::A_CURRENT_RMS_RESULT_TRIM:  r = DW'(state_ff.current_rms_trim);
            rpt_pkg::A_VOLTAGE_RMS_RESULT_RES:   r = DW'(state_ff.voltage_rms_result);
            rpt_pkg::A_CURRENT_RMS_RESULT_RES:   r = DW'(state_ff.current_rms_result);
            rpt_pkg::A_STATUS:     r = DW'(state_ff.stat);
            rpt_pkg::A_MASK:       r = DW'(state_ff.mask);
            default:               r = '0;
        endcase
        return r;
    endfunction : reg_read

    // msb flip adds 2**(TW-1): a negative trim stays below the centre
    assign voff = {~state_ff.phase_trim_value[TW-1],
                   state_ff.phase_trim_value[TW-2:0],
                   {rpt_pkg::PH_STEP_LOG{1'b0}}};

    assign vsum = $signed({2'b00, sq_root}) +
                  VW'($signed(state_ff.voltage_rms_trim));
    assign vclamp = vsum[VW-1] ? '0 : vsum[RW:0];
    assign ichk = $signed({2'b00, state_ff.ims}) +
                  XW'($signed(state_ff.current_rms_trim)) * ISCALE;
    // saturate rather than wrap: a wrapped radicand gives a wild root
    assign icorr = ichk[XW-1] ? '0 : (ichk[MW] ? '1 : ichk[MW-1:0]);
    assign zx = state_ff.vpos != ~state_ff.vdel[SW-1];
    assign aw_hs = axi_awvalid_in & state_ff.awrdy;
    assign w_hs = axi_wvalid_in & state_ff.wrdy;
    assign ar_hs = axi_arvalid_in & state_ff.arrdy;
    assign do_wr = state_ff.haw & state_ff.hw & ~state_ff.bvalid;
    assign mrg = strb_merge(reg_read(state_ff.awa), state_ff.wd,
                            state_ff.ws);
    assign clr = strb_merge('0, state_ff.wd, state_ff.ws);
    assign ev[rpt_pkg::ST_ZX] = zx;
    assign ev[rpt_pkg::ST_VRDY] = sq_done & ~state_ff.sel;
    assign ev[rpt_pkg::ST_IRDY] = sq_done & state_ff.sel;

    rpt_isqrt u_isqrt (
        .ref_clk_in  (ref_clk_in),
        .reset_in    (reset_in),
        .start_in    (state_ff.go),
        .radicand_in (state_ff.rad),
        .busy_out    (sq_busy),
        .done_out    (sq_done),
        .root_out    (sq_root)
    );

    always_comb begin
        nxt_state = state_ff;
        // sample history, both channels side by side
        nxt_state.mem[state_ff.wp] = {voltage_sample_in, current_sample_in};
        nxt_state.wp = state_ff.wp + 1'b1;
        if (voff == '0) begin
            nxt_state.vdel = voltage_sample_in;
        end else begin
            nxt_state.vdel =
                state_ff.mem[state_ff.wp - voff][2*SW-1:SW];
        end
        nxt_state.idel = state_ff.mem[state_ff.wp - IOFF][SW-1:0];
        nxt_state.vpos = ~state_ff.vdel[SW-1];
        nxt_state.vsq = square(state_ff.vdel);
        nxt_state.isq = square(state_ff.idel);
        nxt_state.vms = lpf_step(state_ff.vms, state_ff.vsq);
        nxt_state.ims = lpf_step(state_ff.ims, state_ff.isq);
        // one root engine shared, voltage and current in turn
        if (sq_done) begin
            if (!state_ff.sel) begin
                nxt_state.voltage_rms_result = RSW'(vclamp);
            end else begin
                nxt_state.current_rms_result = RSW'(sq_root);
            end
            nxt_state.sel = ~state_ff.sel;
        end
        nxt_state.go = ~state_ff.go & ~sq_busy & ~sq_done;
        if (nxt_state.go) begin
            nxt_state.rad = state_ff.sel ? icorr : state_ff.vms;
        end
        // write channel
        if (aw_hs) begin
            nxt_state.awa = axi_awaddr_in;
        end
        if (w_hs) begin
            nxt_state.wd = axi_wdata_in;
            nxt_state.ws = axi_wstrb_in;
        end
        nxt_state.haw = (state_ff.haw & ~do_wr) | aw_hs;
        nxt_state.hw = (state_ff.hw & ~do_wr) | w_hs;
        nxt_state.awrdy = ~nxt_state.haw;
        nxt_state.wrdy = ~nxt_state.hw;
        nxt_state.bvalid = (state_ff.bvalid & ~axi_bready_in) | do_wr;
        nxt_state.stat = state_ff.stat | ev;
        if (do_wr) begin
            nxt_state.bresp = addr_hit(state_ff.awa) ? rpt_pkg::RESP_OKAY :
                                                       rpt_pkg::RESP_SLVERR;
            case ({state_ff.awa[BW-1:2], 2'b00})
                rpt_pkg::A_PHASE_TRIM: nxt_state.phase_trim_value = TW'(mrg);
                rpt_pkg::A_VOLTAGE_RMS_RESULT_TRIM:  nxt_state.voltage_rms_trim = OW'(mrg);
                rpt_pkg::A_CURRENT_RMS_RESULT_TRIM:  nxt_state.current_rms_trim = OW'(mrg);
                rpt_pkg::A_MASK:       nxt_state.mask = STW'(mrg);
                // a new event in the same cycle survives the clear
                rpt_pkg::A_STATUS:
                    nxt_state.stat = (state_ff.stat & ~STW'(clr)) | ev;
                default: ;
            endcase
        end
        // read channel
        if (ar_hs) begin
            nxt_state.rdata = reg_read(axi_araddr_in);
            nxt_state.rresp = addr_hit(axi_araddr_in) ? rpt_pkg::RESP_OKAY :
                                                        rpt_pkg::RESP_SLVERR;
        end
        nxt_state.rvalid = (state_ff.rvalid & ~axi_rready_in) | ar_hs;
        nxt_state.arrdy = ~nxt_state.rvalid;
        nxt_state.irq = |(nxt_state.stat & nxt_state.mask);
    end

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_ff <= '0;
            state_ff.phase_trim_value <= rpt_pkg::PH_CENTER;
            state_ff.vpos <= 1'b1;
            state_ff.awrdy <= 1'b1;
            state_ff.wrdy <= 1'b1;
            state_ff.arrdy <= 1'b1;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign axi_awready_out = state_ff.awrdy;
    assign axi_wready_out = state_ff.wrdy;
    assign axi_bresp_out = state_ff.bresp;
    assign axi_bvalid_out = state_ff.bvalid;
    assign axi_arready_out = state_ff.arrdy;
    assign axi_rdata_out = state_ff.rdata;
    assign axi_rresp_out = state_ff.rresp;
    assign axi_rvalid_out = state_ff.rvalid;
    assign irq_out = state_ff.irq;

    // checking helpers
    logic [SW:0]   vabs;
    logic [MW-1:0] vabs_sq;
    logic [XW-1:0] r2lo;
    logic [XW-1:0] r2hi;
    assign vabs = state_ff.vdel[SW-1] ? (SW+1)'(-$signed(state_ff.vdel)) :
                                        (SW+1)'(state_ff.vdel);
    assign vabs_sq = MW'(vabs) * MW'(vabs);
    assign r2lo = XW'(sq_root) * XW'(sq_root);
    assign r2hi = (XW'(sq_root) + XW'(1)) * (XW'(sq_root) + XW'(1));

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);

    sequence s_vroot_done;
        sq_done && !state_ff.sel;
    endsequence
    sequence s_zx_enabled;
        zx && state_ff.mask[rpt_pkg::ST_ZX];
    endsequence

    AST_PH_CENTER: assert property (
        (state_ff.phase_trim_value == rpt_pkg::PH_CENTER) |-> (voff == IOFF))
        else $error("centre trim does not give equal delay");
    AST_PH_DELAY: assert property (
        ($signed(state_ff.phase_trim_value) > $signed(rpt_pkg::PH_CENTER))
        |-> (voff > IOFF))
        else $error("positive trim difference is not a delay");
    AST_PH_SIGNED: assert property (
        state_ff.phase_trim_value[TW-1] |-> (voff < IOFF))
        else $error("negative trim is not an advance");
    AST_SQUARE: assert property (
        1'b1 |=> (state_ff.vsq == $past(vabs_sq)))
        else $error("voltage square wrong");
    AST_ROOT: assert property (
        sq_done |-> (r2lo <= XW'(state_ff.rad)) && (r2hi > XW'(state_ff.rad)))
        else $error("square root out of range");
    AST_VOLTAGE_RMS_RESULT_TRIM: assert property (
        s_vroot_done |=> (state_ff.voltage_rms_result == RSW'($past(vclamp))))
        else $error("voltage rms trim not applied after root");
    AST_CURRENT_RMS_RESULT_TRIM: assert property (
        (nxt_state.go && state_ff.sel && !ichk[XW-1] && !ichk[MW])
        |=> ($signed({2'b00, state_ff.rad}) == $past(ichk)))
        else $error("current rms trim not applied before root");
    AST_ZX_IRQ: assert property (
        s_zx_enabled |=> state_ff.stat[rpt_pkg::ST_ZX] && irq_out)
        else $error("zero crossing did not raise interrupt");
endmodule : rpt_datapath

// ===== verif/rpt_testbench.sv
// self-checking bench for rpt_datapath, integer model at every result
// assumes the design's axi4-lite slave and one 100 MHz clock
`timescale 1ns/1ns
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
    miscompares++; $display("wrong value %s exp %0h got %0h", n, e, g); \
    end end
module testbench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [15:0] vs  = '0;
    logic [15:0] is  = '0;
    logic [7:0]  awa = '0;
    logic [7:0]  ara = '0;
    logic [31:0] wd  = '0;
    logic [3:0]  wst = 4'hF;
    logic        awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
    logic        awr, wr, bv, arr, rv, irq;
    logic [31:0] rd, d;
    logic [1:0]  bre, rre, r;
    logic [5:0]  tl [5] = '{6'h0D, 6'h20, 6'h00, 6'h0B, 6'h1F};
    longint      v, c, vt, it, e, ei, msv = 0, msi = 0;
    int          lat, lat0, xl, miscompares = 0, cmp_count = 0;
    int unsigned seed = 34;

    // shift 1 settles the mean square of a step input at its square, or one short from below
    rpt_datapath #(.LPF_SHIFT(1)) dut_u (
        .ref_clk_in(clk), .reset_in(rst),
        .voltage_sample_in(vs), .current_sample_in(is),
        .axi_awaddr_in(awa), .axi_awvalid_in(awv), .axi_awready_out(awr),
        .axi_wdata_in(wd), .axi_wstrb_in(wst), .axi_wvalid_in(wv),
        .axi_wready_out(wr), .axi_bresp_out(bre), .axi_bvalid_out(bv),
        .axi_bready_in(br), .axi_araddr_in(ara), .axi_arvalid_in(arv),
        .axi_arready_out(arr), .axi_rdata_out(rd), .axi_rresp_out(rre),
        .axi_rvalid_out(rv), .axi_rready_in(rr), .irq_out(irq));

    initial begin
        forever #5 clk = ~clk;
    end

    function automatic int unsigned rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic longint isq(longint x);
        longint q = 0;
        while ((q + 1) * (q + 1) <= x) q++;
        return q;
    endfunction : isq
    // step response: from below it stops one short, from above exact
    function automatic longint lpf(longint ms, longint sq);
        return (sq > ms) ? sq - 1 : sq;
    endfunction : lpf
    task automatic tick(int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task automatic wr_reg(logic [7:0] a, logic [31:0] x, output logic [1:0] o);
        logic ta, tw, tb;
        awa <= a;
        wd  <= x;
        awv <= 1'b1;
        wv  <= 1'b1;
        br  <= 1'b1;
        do begin
            @(negedge clk);
            ta = awv & awr;
            tw = wv & wr;
            tb = bv;
            o  = bre;
            @(posedge clk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
        end while (!tb);
        br <= 1'b0;
        @(posedge clk);
    endtask : wr_reg
    task automatic rd_reg(logic [7:0] a, output logic [31:0] x,
                          output logic [1:0] o);
        logic ta, tb;
        ara <= a;
        arv <= 1'b1;
        rr  <= 1'b1;
        do begin
            @(negedge clk);
            ta = arv & arr;
            tb = rv;
            x  = rd;
            o  = rre;
            @(posedge clk);
            if (ta) arv <= 1'b0;
        end while (!tb);
        rr <= 1'b0;
        @(posedge clk);
    endtask : rd_reg
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results

    // roughly 11k cycles expected, so this only cuts a hang
    initial begin
        #400000;
        miscompares++;
        results();
    end

    initial begin
        tick(4);
        rst <= 1'b0;
        @(posedge clk);
        rd_reg(rpt_pkg::A_PHASE_TRIM, d, r);
        `CHK("phase trim rst", 32'h0000000D, d)
        rd_reg(rpt_pkg::A_VOLTAGE_RMS_RESULT_TRIM, d, r);
        `CHK("voltage_rms_result trim rst", 32'h00000000, d)
        rd_reg(rpt_pkg::A_CURRENT_RMS_RESULT_TRIM, d, r);
        `CHK("current_rms_result trim rst", 32'h00000000, d)
        rd_reg(rpt_pkg::A_MASK, d, r);
        `CHK("mask rst", 32'h00000000, d)
        rd_reg(8'h1C, d, r);
        `CHK("unmapped rresp", rpt_pkg::RESP_SLVERR, r)
        `CHK("unmapped rdata", 32'h00000000, d)
        wr_reg(8'h1C, 32'h00000055, r);
        `CHK("unmapped bresp", rpt_pkg::RESP_SLVERR, r)
        wr_reg(rpt_pkg::A_VOLTAGE_RMS_RESULT_RES, 32'h00000123, r);
        `CHK("ro bresp", rpt_pkg::RESP_OKAY, r)
        rd_reg(rpt_pkg::A_VOLTAGE_RMS_RESULT_RES, d, r);
        `CHK("ro unchanged", 32'h00000000, d)
        wr_reg(rpt_pkg::A_PHASE_TRIM, 32'hFFFFFFFF, r);
        rd_reg(rpt_pkg::A_PHASE_TRIM, d, r);
        `CHK("phase trim width", 32'h0000003F, d)
        wr_reg(rpt_pkg::A_PHASE_TRIM, 32'h0000000D, r);
        // byte strobes merge into the standing value
        wr_reg(rpt_pkg::A_VOLTAGE_RMS_RESULT_TRIM, 32'h00000ABC, r);
        wst <= 4'h1;
        wr_reg(rpt_pkg::A_VOLTAGE_RMS_RESULT_TRIM, 32'h00000F12, r);
        wst <= 4'hF;
        rd_reg(rpt_pkg::A_VOLTAGE_RMS_RESULT_TRIM, d, r);
        `CHK("strobe merge", 32'h00000A12, d)
        // random dc levels and trims against the integer model
        for (int k = 0; k < 3; k++) begin
            v  = 256 + rnd() % 16000;
            c  = $signed(16'(rnd()));
            vt = $signed(12'(rnd()));
            it = $signed(12'(rnd()));
            // channel offset taken out upstream, samples arrive corrected
            vs <= 16'(v);
            is <= 16'(c);
            wr_reg(rpt_pkg::A_VOLTAGE_RMS_RESULT_TRIM, 32'(vt), r);
            wr_reg(rpt_pkg::A_CURRENT_RMS_RESULT_TRIM, 32'(it), r);
            msv = lpf(msv, v * v);
            msi = lpf(msi, c * c);
            tick(800);
            e = isq(msv) + vt;
            if (e < 0) e = 0;
            ei = msi + it * 32768;
            if (ei < 0) ei = 0;
            rd_reg(rpt_pkg::A_VOLTAGE_RMS_RESULT_RES, d, r);
            `CHK("voltage_rms_result", 32'(e), d)
            rd_reg(rpt_pkg::A_CURRENT_RMS_RESULT_RES, d, r);
            `CHK("current_rms_result", 32'(isq(ei)), d)
            rd_reg(rpt_pkg::A_STATUS, d, r);
            `CHK("result flags", 2'b11, d[2:1])
        end
        // masked crossing stays silent until unmasked, then w1c clears
        wr_reg(rpt_pkg::A_STATUS, 32'h00000007, r);
        vs <= 16'h0000 - vs;
        tick(600);
        @(negedge clk);
        `CHK("irq masked", 1'b0, irq)
        @(posedge clk);
        rd_reg(rpt_pkg::A_STATUS, d, r);
        `CHK("zx flag", 1'b1, d[0])
        wr_reg(rpt_pkg::A_MASK, 32'h00000001, r);
        tick(3);
        @(negedge clk);
        `CHK("irq unmasked", 1'b1, irq)
        @(posedge clk);
        wr_reg(rpt_pkg::A_STATUS, 32'h00000001, r);
        tick(3);
        @(negedge clk);
        `CHK("irq cleared", 1'b0, irq)
        @(posedge clk);
        // crossing latency moves by eight clocks per trim step
        foreach (tl[k]) begin
            tick(600);
            wr_reg(rpt_pkg::A_PHASE_TRIM, 32'(tl[k]), r);
            tick(600);
            wr_reg(rpt_pkg::A_STATUS, 32'h00000001, r);
            vs <= 16'h0000 - vs;
            lat = 0;
            do begin
                @(negedge clk);
                lat++;
            end while (irq !== 1'b1 && lat < 1000);
            if (k == 0) lat0 = lat;
            xl = (int'($signed(tl[k])) - 13) * 8;
            `CHK("zx shift", xl, lat - lat0)
        end
        // host reads timed to a voltage crossing, less double-line ripple
        wr_reg(rpt_pkg::A_STATUS, 32'h00000001, r);
        vs <= 16'h0000 - vs;
        lat = 0;
        do begin
            @(negedge clk);
            lat++;
        end while (irq !== 1'b1 && lat < 1000);
        `CHK("sync crossing", 1'b1, irq)
        @(posedge clk);
        rd_reg(rpt_pkg::A_CURRENT_RMS_RESULT_RES, d, r);
        `CHK("current_rms_result after trims", 32'(isq(ei)), d)
        rd_reg(rpt_pkg::A_VOLTAGE_RMS_RESULT_RES, d, r);
        `CHK("voltage_rms_result after trims", 32'(e), d)
        results();
    end
endmodule : testbench
